// ### hdl/dag_mac_agu.sv
`timescale 1ns/1ps
`default_nettype none
// one prefetch address unit; X uses regs 8/9, Y uses 10/11
module dag_mac_agu
    import dag_pkg::*;
(
    input wire logic [1:0] mode,
    input wire logic sel_b,
    input wire logic [1:0] step_sel,
    input wire logic [WORD_W-1:0] reg_a,
    input wire logic [WORD_W-1:0] reg_b,
    input wire logic [WORD_W-1:0] index_val,
    output logic [WORD_W-1:0] ea,
    output logic [WORD_W-1:0] wb_val,
    output logic wb_en,
    output logic illegal
);
    logic [WORD_W-1:0] ptr;
    logic [WORD_W-1:0] step;

    assign ptr = sel_b ? reg_b : reg_a;
    // step_sel 1..3 means +2, +4, +6; 0 is reserved and flagged
    assign step = WORD_W'({step_sel, 1'b0});

    always_comb begin
        ea = ptr;
        wb_val = ptr;
        wb_en = 1'b0;
        illegal = 1'b0;
        case (mode)
            DAG_MAC_IND: begin
                ea = ptr;
            end
            DAG_MAC_POST: begin
                wb_val = ptr + step;
                wb_en = 1'b1;
                illegal = (step_sel == 2'h0);
            end
            DAG_MAC_INDEXED: begin
                ea = ptr + index_val;
                illegal = !sel_b;
            end
            default: begin
                ea = ptr;
            end
        endcase
    end
endmodule
`default_nettype wire

// ### hdl/dag_pager.sv
`timescale 1ns/1ps
`default_nettype none
// one paging unit, used for the read path and the write path
module dag_pager
    import dag_pkg::*;
#(
    parameter int PAGE_W = 10,
    parameter logic [PAGE_W-1:0] PAGE_RST = '0
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic page_wr,
    input wire logic [PAGE_W-1:0] page_wdata,
    input wire logic access,
    input wire logic no_page,
    input wire logic [WORD_W-1:0] ea,
    output logic [PAGE_W-1:0] page_q,
    output logic [XADDR_W-1:0] xaddr,
    output logic addr_err
);
    logic paged;

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            page_q <= PAGE_RST;
        end else if (page_wr && page_wdata != '0) begin
            page_q <= page_wdata;
        end
    end

    assign paged = ea[EA_HI_BIT] && !no_page;

    always_comb begin
        if (paged) begin
            xaddr = {page_q[PAGE_LO_W-1:0], ea[EA_HI_BIT-1:0]};
        end else begin
            xaddr = {{(XADDR_W-WORD_W){1'b0}}, ea};
        end
    end

    assign addr_err = access && paged && (page_q == '0);

    AST_PAGE_NEVER_ZERO: assert property (@(posedge clk_sys) disable iff (srst)
        page_q != '0) else $error("page register reached zero");
    AST_PAGE_ZERO_WRITE_IGNORED: assert property (@(posedge clk_sys) disable iff (srst)
        (page_wr && page_wdata == '0) |=> $stable(page_q)) else $error("zero write changed page");
endmodule
`default_nettype wire

// ### hdl/dag_pkg.sv
package dag_pkg;
    localparam int WORD_W = 16;
    localparam int XADDR_W = 24;
    localparam int RPAGE_W = 10;
    localparam int WPAGE_W = 9;
    localparam int NUM_WREGS = 16;
    localparam logic [RPAGE_W-1:0] RPAGE_RESET = 10'h001;
    localparam logic [WPAGE_W-1:0] WPAGE_RESET = 9'h001;
    localparam logic [RPAGE_W-1:0] RPAGE_ZERO = 10'h000;
    localparam logic [WPAGE_W-1:0] WPAGE_ZERO = 9'h000;
    localparam logic [WORD_W-1:0] SP_RESET = 16'h1000;
    localparam logic [WORD_W-1:0] DIRECT_TOP = 16'h2FFF;
    localparam int EA_HI_BIT = 15;
    localparam int PAGE_LO_W = 9;
    localparam int PC_W = 23;
    localparam int PC_HI_W = 7;
    localparam int SR_LO_W = 8;
    localparam int FILE_ADDR_W = 13;
    localparam int LIT5_W = 5;
    localparam int LIT14_W = 14;
    localparam logic [3:0] SP_IDX = 4'hF;
    localparam logic [3:0] FP_IDX = 4'hE;
    localparam logic [3:0] XA_IDX = 4'h8;
    localparam logic [3:0] XB_IDX = 4'h9;
    localparam logic [3:0] YA_IDX = 4'hA;
    localparam logic [3:0] YB_IDX = 4'hB;
    localparam logic [WORD_W-1:0] WORD_STEP = 16'h0002;

    typedef enum logic [2:0] {
        DAG_AM_DIRECT = 3'h0,
        DAG_AM_IND = 3'h1,
        DAG_AM_POST = 3'h2,
        DAG_AM_PRE = 3'h3,
        DAG_AM_INDEXED = 3'h4,
        DAG_AM_LITOFS = 3'h5,
        DAG_AM_FILE = 3'h6,
        DAG_AM_LIT = 3'h7
    } dag_mode_e;

    typedef enum logic [1:0] {
        DAG_MAC_IND = 2'h0,
        DAG_MAC_POST = 2'h1,
        DAG_MAC_INDEXED = 2'h2,
        DAG_MAC_NONE = 2'h3
    } dag_mac_mode_e;

    typedef enum logic [1:0] {
        DAG_ST_IDLE = 2'h0,
        DAG_ST_PUSH_HI = 2'h1,
        DAG_ST_POP_LO = 2'h2
    } dag_stk_e;
endpackage

// ### hdl/dag_top.sv
`timescale 1ns/1ps
`default_nettype none
module dag_top
    import dag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    // register file write port from execute
    input wire logic default_work_reg_we,
    input wire logic [3:0] default_work_reg_waddr,
    input wire logic [WORD_W-1:0] default_work_reg_wdata,
    // page register software writes
    input wire logic rpage_we,
    input wire logic [RPAGE_W-1:0] rpage_wdata,
    input wire logic wpage_we,
    input wire logic [WPAGE_W-1:0] wpage_wdata,
    input wire logic frame_active_flag,
    // operand address request
    input wire logic op_valid,
    input wire logic op_is_write,
    input wire logic op_is_move,
    input wire logic [2:0] op_mode,
    input wire logic [3:0] op_ptr_idx,
    input wire logic [3:0] op_base_idx,
    input wire logic [3:0] op_offset_idx,
    input wire logic [WORD_W-1:0] op_mod_const,
    input wire logic [WORD_W-1:0] op_literal,
    input wire logic [FILE_ADDR_W-1:0] op_file_addr,
    // MAC prefetch
    input wire logic mac_valid,
    input wire logic [1:0] mac_x_mode,
    input wire logic mac_x_sel_b,
    input wire logic [1:0] mac_x_step,
    input wire logic [1:0] mac_y_mode,
    input wire logic mac_y_sel_b,
    input wire logic [1:0] mac_y_step,
    // stack operations
    input wire logic push_word,
    input wire logic [WORD_W-1:0] push_data,
    input wire logic pop_word,
    input wire logic push_pc,
    input wire logic push_is_exc,
    input wire logic [PC_W-1:0] pc_in,
    input wire logic [SR_LO_W-1:0] status_low_byte,
    // branch / hold literal decode
    input wire logic [WORD_W-1:0] branch_lit,
    input wire logic [LIT14_W-1:0] hold_lit,
    output logic [WORD_W-1:0] branch_offset,
    output logic [WORD_W-1:0] hold_count,
    // results
    output logic [WORD_W-1:0] base_operand,
    output logic [WORD_W-1:0] operand2,
    output logic operand2_is_reg,
    output logic [XADDR_W-1:0] data_addr,
    output logic data_addr_valid,
    output logic data_we,
    output logic [WORD_W-1:0] data_wdata,
    output logic addr_err_trap,
    output logic mode_err,
    output logic [WORD_W-1:0] mac_x_addr,
    output logic [WORD_W-1:0] mac_y_addr,
    output logic mac_addr_valid,
    output logic [RPAGE_W-1:0] read_page_reg,
    output logic [WPAGE_W-1:0] write_page_reg,
    output logic [WORD_W-1:0] stack_ptr_reg,
    output logic stack_busy
);
    logic [WORD_W-1:0] wregs_q [NUM_WREGS];
    logic [WORD_W-1:0] ptr_val;
    logic [WORD_W-1:0] ea;
    logic [WORD_W-1:0] ptr_new;
    logic ptr_wb;
    logic ea_valid;
    logic ea_no_page;
    logic [XADDR_W-1:0] rd_xaddr;
    logic [XADDR_W-1:0] wr_xaddr;
    logic rd_err;
    logic wr_err;
    logic [WORD_W-1:0] mac_x_ea, mac_y_ea, mac_x_wb, mac_y_wb;
    logic mac_x_wbe, mac_y_wbe, mac_x_ill, mac_y_ill;
    dag_stk_e stk_q, stk_d;
    logic [WORD_W-1:0] pc_hi_word_q;
    logic [WORD_W-1:0] sp;
    logic [WORD_W-1:0] sp_next;
    logic stk_access;
    logic [WORD_W-1:0] stk_addr;
    logic [WORD_W-1:0] stk_wdata;
    logic stk_we;
    logic sp_upd;

    assign sp = wregs_q[SP_IDX];
    assign ptr_val = wregs_q[op_ptr_idx];
    assign base_operand = wregs_q[op_base_idx];
    // literal operand 2 is the low 5 bits for ordinary MCU forms
    assign operand2_is_reg = (op_mode != DAG_AM_LIT);
    assign operand2 = (op_mode == DAG_AM_LIT) ?
        (op_is_move ? op_literal : {{(WORD_W-LIT5_W){1'b0}}, op_literal[LIT5_W-1:0]}) : ptr_val;
    assign branch_offset = branch_lit;
    assign hold_count = {{(WORD_W-LIT14_W){1'b0}}, hold_lit};

    // effective address for the single-operand path
    always_comb begin
        ea = ptr_val;
        ptr_new = ptr_val;
        ptr_wb = 1'b0;
        ea_valid = op_valid;
        mode_err = 1'b0;
        case (op_mode)
            DAG_AM_IND: begin
                ea = ptr_val;
            end
            DAG_AM_POST: begin
                ea = ptr_val;
                ptr_new = ptr_val + op_mod_const;
                ptr_wb = op_valid;
            end
            DAG_AM_PRE: begin
                ea = ptr_val + op_mod_const;
                ptr_new = ptr_val + op_mod_const;
                ptr_wb = op_valid;
            end
            DAG_AM_INDEXED: begin
                // shared offset field for both move operands
                ea = ptr_val + wregs_q[op_offset_idx];
                mode_err = op_valid && !op_is_move;
            end
            DAG_AM_LITOFS: begin
                ea = ptr_val + op_literal;
            end
            DAG_AM_FILE: begin
                ea = {{(WORD_W-FILE_ADDR_W){1'b0}}, op_file_addr};
            end
            default: begin
                ea_valid = 1'b0;
            end
        endcase
        if (mac_valid && (mac_x_ill || mac_y_ill)) begin
            mode_err = 1'b1;
        end
    end

    assign ea_no_page = (op_ptr_idx == SP_IDX) ||
        (op_ptr_idx == FP_IDX && frame_active_flag) || (op_mode == DAG_AM_FILE);

    dag_pager #(.PAGE_W(RPAGE_W), .PAGE_RST(RPAGE_RESET)) u_rpage (
        .clk_sys(clk_sys), .srst(srst),
        .page_wr(rpage_we), .page_wdata(rpage_wdata),
        .access(ea_valid && !op_is_write && !stk_access),
        .no_page(ea_no_page), .ea(ea),
        .page_q(read_page_reg), .xaddr(rd_xaddr), .addr_err(rd_err)
    );

    dag_pager #(.PAGE_W(WPAGE_W), .PAGE_RST(WPAGE_RESET)) u_wpage (
        .clk_sys(clk_sys), .srst(srst),
        .page_wr(wpage_we), .page_wdata(wpage_wdata),
        .access(ea_valid && op_is_write && !stk_access),
        .no_page(ea_no_page), .ea(ea),
        .page_q(write_page_reg), .xaddr(wr_xaddr), .addr_err(wr_err)
    );

    dag_mac_agu u_xagu (
        .mode(mac_x_mode), .sel_b(mac_x_sel_b), .step_sel(mac_x_step),
        .reg_a(wregs_q[XA_IDX]), .reg_b(wregs_q[XB_IDX]), .index_val(wregs_q[YB_IDX + 4'h1]),
        .ea(mac_x_ea), .wb_val(mac_x_wb), .wb_en(mac_x_wbe), .illegal(mac_x_ill)
    );

    dag_mac_agu u_yagu (
        .mode(mac_y_mode), .sel_b(mac_y_sel_b), .step_sel(mac_y_step),
        .reg_a(wregs_q[YA_IDX]), .reg_b(wregs_q[YB_IDX]), .index_val(wregs_q[YB_IDX + 4'h1]),
        .ea(mac_y_ea), .wb_val(mac_y_wb), .wb_en(mac_y_wbe), .illegal(mac_y_ill)
    );

    // stack sequencer: a PC push takes two cycles, high word second
    always_comb begin
        stk_d = stk_q;
        stk_access = 1'b0;
        stk_addr = sp;
        stk_wdata = push_data;
        stk_we = 1'b0;
        sp_upd = 1'b0;
        sp_next = sp;
        case (stk_q)
            DAG_ST_IDLE: begin
                if (push_pc) begin
                    stk_access = 1'b1;
                    stk_we = 1'b1;
                    stk_wdata = pc_in[WORD_W-1:0];
                    sp_upd = 1'b1;
                    sp_next = sp + WORD_STEP;
                    stk_d = DAG_ST_PUSH_HI;
                end else if (push_word) begin
                    stk_access = 1'b1;
                    stk_we = 1'b1;
                    sp_upd = 1'b1;
                    sp_next = sp + WORD_STEP;
                end else if (pop_word) begin
                    stk_access = 1'b1;
                    stk_addr = sp - WORD_STEP;
                    sp_upd = 1'b1;
                    sp_next = sp - WORD_STEP;
                end
            end
            DAG_ST_PUSH_HI: begin
                stk_access = 1'b1;
                stk_we = 1'b1;
                stk_wdata = pc_hi_word_q;
                sp_upd = 1'b1;
                sp_next = sp + WORD_STEP;
                stk_d = DAG_ST_IDLE;
            end
            default: begin
                stk_d = DAG_ST_IDLE;
            end
        endcase
    end

    assign stack_busy = (stk_q != DAG_ST_IDLE);

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            stk_q <= DAG_ST_IDLE;
            pc_hi_word_q <= '0;
        end else begin
            stk_q <= stk_d;
            if (stk_q == DAG_ST_IDLE && push_pc) begin
                pc_hi_word_q <= {(push_is_exc ? status_low_byte : {SR_LO_W{1'b0}}), 1'b0,
                    pc_in[PC_W-1:WORD_W]};
            end
        end
    end

    // working registers; stack update beats a software write to the stack pointer
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            for (int i = 0; i < NUM_WREGS; i++) begin
                wregs_q[i] <= (i == int'(SP_IDX)) ? SP_RESET : '0;
            end
        end else begin
            if (default_work_reg_we) begin
                wregs_q[default_work_reg_waddr] <= default_work_reg_wdata;
            end
            if (ptr_wb && !stk_access) begin
                wregs_q[op_ptr_idx] <= ptr_new;
            end
            if (mac_valid && mac_x_wbe) begin
                wregs_q[mac_x_sel_b ? XB_IDX : XA_IDX] <= mac_x_wb;
            end
            if (mac_valid && mac_y_wbe) begin
                wregs_q[mac_y_sel_b ? YB_IDX : YA_IDX] <= mac_y_wb;
            end
            if (sp_upd) begin
                wregs_q[SP_IDX] <= sp_next;
            end
            wregs_q[SP_IDX][0] <= 1'b0;
        end
    end

    assign stack_ptr_reg = {sp[WORD_W-1:1], 1'b0};

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            data_addr <= '0;
            data_addr_valid <= 1'b0;
            data_we <= 1'b0;
            data_wdata <= '0;
            addr_err_trap <= 1'b0;
            mac_x_addr <= '0;
            mac_y_addr <= '0;
            mac_addr_valid <= 1'b0;
        end else begin
            addr_err_trap <= !stk_access && (rd_err || wr_err);
            data_wdata <= stk_wdata;
            if (stk_access) begin
                data_addr <= {{(XADDR_W-WORD_W){1'b0}}, stk_addr};
                data_addr_valid <= 1'b1;
                data_we <= stk_we;
            end else begin
                data_addr <= op_is_write ? wr_xaddr : rd_xaddr;
                data_addr_valid <= ea_valid && !(rd_err || wr_err);
                data_we <= ea_valid && op_is_write;
            end
            mac_x_addr <= mac_x_ea;
            mac_y_addr <= mac_y_ea;
            mac_addr_valid <= mac_valid && !mac_x_ill && !mac_y_ill;
        end
    end

    AST_SP_ALIGNED: assert property (@(posedge clk_sys) disable iff (srst)
        stack_ptr_reg[0] == 1'b0) else $error("stack pointer misaligned");
    AST_SP_RESET: assert property (@(posedge clk_sys)
        srst |=> stack_ptr_reg == SP_RESET) else $error("stack pointer reset value wrong");
    AST_PAGE_RESET: assert property (@(posedge clk_sys)
        srst |=> (read_page_reg == RPAGE_RESET && write_page_reg == WPAGE_RESET))
        else $error("page reset value wrong");
    AST_PUSH_INC: assert property (@(posedge clk_sys) disable iff (srst)
        (stk_q == DAG_ST_IDLE && push_word && !push_pc && !default_work_reg_we) |=>
        stack_ptr_reg == $past(stack_ptr_reg) + WORD_STEP) else $error("push did not increment");
    AST_POP_ADDR: assert property (@(posedge clk_sys) disable iff (srst)
        (stk_q == DAG_ST_IDLE && pop_word && !push_pc && !push_word) |=>
        (data_addr[WORD_W-1:0] == $past(sp) - WORD_STEP && !data_we)) else $error("pop address wrong");
    sequence s_pc_push;
        (stk_q == DAG_ST_IDLE && push_pc) ##1 stk_q == DAG_ST_PUSH_HI;
    endsequence
    AST_PC_HI_SECOND: assert property (@(posedge clk_sys) disable iff (srst)
        s_pc_push |=> (data_we && data_wdata[PC_HI_W-1:0] == $past(pc_in[PC_W-1:WORD_W], 2)))
        else $error("pc high word wrong");
    AST_LOW_DIRECT: assert property (@(posedge clk_sys) disable iff (srst)
        (ea_valid && !stk_access && ea <= DIRECT_TOP) |=> data_addr == XADDR_W'($past(ea)))
        else $error("low range not direct");
    AST_SP_UNPAGED: assert property (@(posedge clk_sys) disable iff (srst)
        (ea_valid && !stk_access && op_ptr_idx == SP_IDX) |=> data_addr[XADDR_W-1:WORD_W] == '0)
        else $error("stack address paged");
    AST_ZERO_PAGE_TRAP: assert property (@(posedge clk_sys) disable iff (srst)
        (rd_err && !stk_access) |=> (addr_err_trap && !data_addr_valid)) else $error("no trap on page zero");
endmodule
`default_nettype wire

// ### tb/dag_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// far-side data memory; a word never written reads back as the inverted address
// so a stale or unknown value cannot pass for real data
module dag_mem_model
    import dag_pkg::*;
(
    input wire logic clk_sys,
    input wire logic valid,
    input wire logic we,
    input wire logic [XADDR_W-1:0] addr,
    input wire logic [WORD_W-1:0] wdata,
    output logic [WORD_W-1:0] rdata
);
    logic [WORD_W-1:0] mem [int];
    logic [WORD_W-1:0] rd_word;
    always @(posedge clk_sys) begin
        if (valid === 1'h1 && we === 1'h1) begin
            mem[addr] = wdata;
            rdata <= ~rd_word;
        end else if (valid === 1'h1) begin
            rd_word = mem.exists(addr) ? mem[addr] : ~addr[WORD_W-1:0];
            rdata <= rd_word;
        end else begin
            rdata <= ~rd_word;
        end
    end
endmodule
`default_nettype wire

// ### tb/dag_top_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dag_top_tb;
    import dag_pkg::*;
    typedef struct packed {logic [XADDR_W-1:0] a; logic we; logic [WORD_W-1:0] d; logic chk;} dag_exp_s;
    logic clk_sys = 1'h0;
    logic srst = 1'h1;
    logic default_work_reg_we = 1'h0, rpage_we = 1'h0, wpage_we = 1'h0, frame_active_flag = 1'h0;
    logic op_valid = 1'h0, op_is_write = 1'h0, op_is_move = 1'h1, mac_valid = 1'h0;
    logic mac_x_sel_b = 1'h0, mac_y_sel_b = 1'h0, push_word = 1'h0, pop_word = 1'h0;
    logic push_pc = 1'h0, push_is_exc = 1'h0;
    logic [3:0] default_work_reg_waddr = 4'h0, op_ptr_idx = 4'h0, op_base_idx = 4'h5, op_offset_idx = 4'h5;
    logic [WORD_W-1:0] default_work_reg_wdata = '0, op_mod_const = '0, op_literal = '0, push_data = '0, branch_lit = '0;
    logic [RPAGE_W-1:0] rpage_wdata = '0;
    logic [WPAGE_W-1:0] wpage_wdata = '0;
    logic [2:0] op_mode = 3'h1;
    logic [FILE_ADDR_W-1:0] op_file_addr = '0;
    logic [1:0] mac_x_mode = 2'h0, mac_y_mode = 2'h0, mac_x_step = 2'h1, mac_y_step = 2'h1;
    logic [PC_W-1:0] pc_in = '0;
    logic [SR_LO_W-1:0] status_low_byte = '0;
    logic [LIT14_W-1:0] hold_lit = '0;
    logic [WORD_W-1:0] branch_offset, hold_count, mac_x_addr, mac_y_addr, stack_ptr_reg, data_wdata, rdata;
    logic [XADDR_W-1:0] data_addr;
    logic data_addr_valid, data_we, addr_err_trap, mode_err, mac_addr_valid, me;
    logic [WORD_W-1:0] base_operand, operand2;
    logic operand2_is_reg, stack_busy;
    logic [RPAGE_W-1:0] read_page_reg;
    logic [WPAGE_W-1:0] write_page_reg;
    logic [WORD_W-1:0] w [NUM_WREGS];
    logic [WORD_W-1:0] sp;
    logic [8:0] rp, wp;
    dag_exp_s expq [$];
    dag_exp_s em;
    int err_total = 0;
    int check_count = 0;
    int i;

    dag_top DUT (.clk_sys, .srst, .default_work_reg_we, .default_work_reg_waddr, .default_work_reg_wdata, .rpage_we, .rpage_wdata,
        .wpage_we, .wpage_wdata, .frame_active_flag, .op_valid, .op_is_write, .op_is_move, .op_mode,
        .op_ptr_idx, .op_base_idx, .op_offset_idx, .op_mod_const, .op_literal, .op_file_addr,
        .mac_valid, .mac_x_mode, .mac_x_sel_b, .mac_x_step, .mac_y_mode, .mac_y_sel_b, .mac_y_step,
        .push_word, .push_data, .pop_word, .push_pc, .push_is_exc, .pc_in, .status_low_byte,
        .branch_lit, .hold_lit, .branch_offset, .hold_count, .base_operand, .operand2,
        .operand2_is_reg, .data_addr, .data_addr_valid, .data_we, .data_wdata, .addr_err_trap,
        .mode_err, .mac_x_addr, .mac_y_addr, .mac_addr_valid, .read_page_reg, .write_page_reg,
        .stack_ptr_reg, .stack_busy);
    dag_mem_model mem (.clk_sys, .valid(data_addr_valid), .we(data_we), .addr(data_addr),
        .wdata(data_wdata), .rdata);

    initial begin
        forever #2 clk_sys = ~clk_sys;
    end

    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s exp=%0h seen=%0h", nm, exp, seen);
        end
    endtask

    task finish_test;
        $display("mismatches=%0d checks=%0d", err_total, check_count);
        if (err_total == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic setw(input logic [3:0] idx, input logic [15:0] v);
        @(posedge clk_sys);
        default_work_reg_we <= 1'h1;
        default_work_reg_waddr <= idx;
        default_work_reg_wdata <= v;
        w[idx] = v;
        if (idx == SP_IDX) sp = {v[15:1], 1'h0};
        @(posedge clk_sys);
        default_work_reg_we <= 1'h0;
    endtask

    task automatic pg(input logic [9:0] rv, input logic [8:0] wv);
        @(posedge clk_sys);
        rpage_we <= 1'h1;
        rpage_wdata <= rv;
        wpage_we <= 1'h1;
        wpage_wdata <= wv;
        if (rv != 10'h000) rp = rv[8:0];
        if (wv != 9'h000) wp = wv;
        @(posedge clk_sys);
        rpage_we <= 1'h0;
        wpage_we <= 1'h0;
    endtask

    // expectation follows the pointer arithmetic, paging applies only with ea bit 15 set
    task automatic op(input dag_mode_e m, input logic [3:0] p, input logic [15:0] k, input logic wr);
        logic [15:0] ea;
        logic unp;
        ea = (m == DAG_AM_INDEXED) ? w[p] + w[5] : (m == DAG_AM_FILE) ? {3'h0, k[12:0]} :
            (m == DAG_AM_PRE || m == DAG_AM_LITOFS) ? w[p] + k : w[p];
        if (m == DAG_AM_POST || m == DAG_AM_PRE) w[p] = (m == DAG_AM_PRE) ? ea : w[p] + k;
        unp = (m == DAG_AM_FILE) || (p == FP_IDX && frame_active_flag);
        expq.push_back('{(ea[15] && !unp) ? {wr ? wp : rp, ea[14:0]} : {8'h00, ea}, wr, 16'h0000, 1'h0});
        @(posedge clk_sys);
        op_valid <= 1'h1;
        op_mode <= m;
        op_ptr_idx <= p;
        op_mod_const <= k;
        op_literal <= k;
        op_file_addr <= k[12:0];
        op_is_write <= wr;
        @(posedge clk_sys);
        op_valid <= 1'h0;
    endtask

    task automatic stk(input logic pop, input logic [15:0] d);
        if (pop) sp = sp - 16'h0002;
        expq.push_back('{{8'h00, sp}, !pop, d, !pop});
        if (!pop) sp = sp + 16'h0002;
        @(posedge clk_sys);
        push_word <= !pop;
        pop_word <= pop;
        push_data <= d;
        @(posedge clk_sys);
        push_word <= 1'h0;
        pop_word <= 1'h0;
    endtask

    task automatic pcpush(input logic [22:0] pc, input logic exc, input logic [7:0] sr);
        expq.push_back('{{8'h00, sp}, 1'h1, pc[15:0], 1'h1});
        expq.push_back('{{8'h00, sp + 16'h0002}, 1'h1, {exc ? sr : 8'h00, 1'h0, pc[22:16]}, 1'h1});
        sp = sp + 16'h0004;
        @(posedge clk_sys);
        push_pc <= 1'h1;
        push_is_exc <= exc;
        pc_in <= pc;
        status_low_byte <= sr;
        @(posedge clk_sys);
        push_pc <= 1'h0;
        #1 check("pc push busy", stack_busy, 1);
        // second word still going out, no new stack request yet
        @(posedge clk_sys);
    endtask

    task automatic mac(input dag_mac_mode_e md, input logic b, input logic [1:0] st);
        @(posedge clk_sys);
        mac_valid <= 1'h1;
        mac_x_mode <= md;
        mac_y_mode <= md;
        mac_x_sel_b <= b;
        mac_y_sel_b <= b;
        mac_x_step <= st;
        mac_y_step <= st;
        #1 me = mode_err;
        @(posedge clk_sys);
        mac_valid <= 1'h0;
        #1;
    endtask

    task drain;
        for (int n = 0; n < 20 && expq.size() > 0; n++) @(posedge clk_sys);
        if (expq.size() > 0) begin
            err_total++;
            finish_test();
        end
    endtask

    always @(negedge clk_sys) begin
        if (srst === 1'h0 && (data_addr_valid === 1'h1 || addr_err_trap === 1'h1)) begin
            if (expq.size() == 0) begin
                check("spurious access", 1, 0);
            end else begin
                em = expq.pop_front();
                check("trap", addr_err_trap, 0);
                check("data_addr", data_addr, em.a);
                check("data_we", data_we, em.we);
                if (em.chk) check("data_wdata", data_wdata, em.d);
            end
        end
    end

    initial begin
        void'($urandom(83697));
        foreach (w[j]) w[j] = '0;
        sp = SP_RESET;
        rp = 9'h001;
        wp = 9'h001;
        repeat (20) @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        #1;
        check("rpage", read_page_reg, RPAGE_RESET);
        check("wpage", write_page_reg, WPAGE_RESET);
        check("sp", stack_ptr_reg, SP_RESET);
        setw(4'h1, 16'h2FFE);
        setw(4'h2, 16'h8004);
        setw(4'h5, 16'($urandom));
        op(DAG_AM_IND, 4'h1, 16'h0000, 1'h0);
        op(DAG_AM_IND, 4'h2, 16'h0000, 1'h1);
        pg(10'h002, 9'h003);
        pg(10'h000, 9'h000);
        op(DAG_AM_IND, 4'h2, 16'h0000, 1'h0);
        op(DAG_AM_IND, 4'h2, 16'h0000, 1'h1);
        check("rpage kept", read_page_reg, 10'h002);
        check("wpage kept", write_page_reg, 9'h003);
        setw(4'h3, 16'h7FFE);
        op(DAG_AM_POST, 4'h3, 16'h0002, 1'h0);
        op(DAG_AM_IND, 4'h3, 16'h0000, 1'h0);
        op(DAG_AM_PRE, 4'h3, 16'hFFFE, 1'h1);
        op(DAG_AM_LITOFS, 4'h3, 16'h0010, 1'h0);
        op(DAG_AM_IND, 4'h3, 16'h0000, 1'h0);
        for (i = 0; i < 12; i++) begin
            setw(4'h4, 16'($urandom));
            op(dag_mode_e'(3'h1 + 3'($urandom_range(5))), 4'h4, 16'($urandom), 1'($urandom));
        end
        drain();
        setw(4'h8, 16'h0200);
        setw(4'h9, 16'h0300);
        setw(4'hA, 16'h0400);
        setw(4'hB, 16'h0500);
        setw(4'hC, 16'h0010);
        for (i = 1; i < 4; i++) begin
            mac(DAG_MAC_POST, 1'h0, 2'(i));
            check("mac x", mac_x_addr, w[8]);
            check("mac y", mac_y_addr, w[10]);
            check("mac valid", mac_addr_valid, 1);
            w[8] = w[8] + 16'(2 * i);
            w[10] = w[10] + 16'(2 * i);
        end
        mac(DAG_MAC_IND, 1'h0, 2'h1);
        check("mac x wb", mac_x_addr, 16'h020C);
        check("mac y wb", mac_y_addr, 16'h040C);
        mac(DAG_MAC_INDEXED, 1'h0, 2'h1);
        check("mac idx illegal", me, 1);
        mac(DAG_MAC_INDEXED, 1'h1, 2'h1);
        check("mac idx legal", me, 0);
        check("mac x idx", mac_x_addr, 16'h0310);
        check("mac y idx", mac_y_addr, 16'h0510);
        stk(1'h0, 16'hA5C3);
        stk(1'h0, 16'h3C5A);
        stk(1'h1, 16'h0000);
        @(posedge clk_sys);
        #1;
        check("pop data", rdata, 16'h3C5A);
        check("sp after pop", stack_ptr_reg, sp);
        drain();
        pcpush(23'h5A1234, 1'h0, 8'hC3);
        pcpush(23'h2B5678, 1'h1, 8'h96);
        drain();
        check("sp after pc", stack_ptr_reg, sp);
        setw(SP_IDX, 16'h9001);
        @(posedge clk_sys);
        #1;
        check("sp written", stack_ptr_reg, 16'h9000);
        stk(1'h0, 16'h1111);
        frame_active_flag <= 1'h1;
        setw(FP_IDX, 16'hC000);
        op(DAG_AM_IND, FP_IDX, 16'h0000, 1'h0);
        @(posedge clk_sys);
        branch_lit <= 16'($urandom);
        hold_lit <= 14'($urandom);
        op_mode <= DAG_AM_LIT;
        op_is_move <= 1'h0;
        op_literal <= 16'($urandom);
        @(posedge clk_sys);
        #1;
        check("branch", branch_offset, branch_lit);
        check("hold", hold_count, {2'h0, hold_lit});
        check("base operand", base_operand, w[5]);
        check("lit5", operand2, {11'h000, op_literal[4:0]});
        check("op2 is reg", operand2_is_reg, 0);
        @(posedge clk_sys);
        op_is_move <= 1'h1;
        @(posedge clk_sys);
        #1;
        check("lit16", operand2, op_literal);
        drain();
        @(posedge clk_sys);
        srst <= 1'h1;
        repeat (2) @(posedge clk_sys);
        srst <= 1'h0;
        @(posedge clk_sys);
        #1;
        check("rpage rst", read_page_reg, RPAGE_RESET);
        check("wpage rst", write_page_reg, WPAGE_RESET);
        check("sp rst", stack_ptr_reg, SP_RESET);
        finish_test();
    end
endmodule
`default_nettype wire
